/* hdl/oled_reset_power_sequence.sv */
// Purpose: display controller core state, command parser and reset defaults
// Assumes: hw_reset_n pin asynchronous; register port on CLK (20 MHz)
// Notes: while hw_reset_n is low every state except DATA_BYTE holds its default and bytes are dropped
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - reset pin low: defaults, display off
// - reset selects 128x64 display geometry
// - reset gives normal segment and row mapping
// - reset clears serial shift register
// - reset sets start line to row 0
// - reset zeroes column address counter
// - reset gives normal row scan direction
// - reset loads contrast with 7Fh
// - reset selects normal display, like A4h and A6h
module oled_reset_power_sequence (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic HW_RESET_N,
  input wire logic SER_CLK,
  input wire logic SER_DIN,
  input wire logic SER_CS_N,
  input wire logic SER_DC,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [7:0] RDATA,
  output logic DISPLAY_ON,
  output logic [7:0] CONTRAST,
  output logic [5:0] MUX_RATIO,
  output logic [5:0] START_LINE,
  output logic [6:0] COL_ADDR,
  output logic SEG_REMAP,
  output logic COM_REVERSE,
  output logic ENTIRE_ON,
  output logic INVERT,
  output logic CMD_READY,
  output logic DATA_STB,
  output logic [7:0] DATA_BYTE
);

  // ------------------------------------------------------------------
  // reset pin synchroniser
  // ------------------------------------------------------------------
  logic hw_rst_s1_reg; // first stage only
  logic hw_rst_s2_reg; // synchronised hw_reset_n

  // two flops before any logic reads the pin
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hw_rst_s1_reg <= 1'b0;
      hw_rst_s2_reg <= 1'b0;
    end else begin
      hw_rst_s1_reg <= HW_RESET_N;
      hw_rst_s2_reg <= hw_rst_s1_reg;
    end
  end

  wire in_reset = ~hw_rst_s2_reg; // defaults forced while high

  // ------------------------------------------------------------------
  // serial host interface
  // ------------------------------------------------------------------
  logic ser_valid; // one-cycle byte pulse
  logic [7:0] ser_byte; // received byte
  logic ser_is_data; // data/command flag

  serial_byte_receiver #(
    .BITS(oled_init_pkg::SER_BITS)
  ) u_rx (
    .clk(CLK),
    .reset_n(RESET_N),
    .clear(in_reset),
    .ser_clk(SER_CLK),
    .ser_din(SER_DIN),
    .ser_cs_n(SER_CS_N),
    .ser_dc(SER_DC),
    .byte_valid(ser_valid),
    .byte_out(ser_byte),
    .byte_is_data(ser_is_data)
  );

  // ------------------------------------------------------------------
  // byte source selection
  // ------------------------------------------------------------------
  logic pend_reg; // serial byte waiting behind a port write
  logic [7:0] pend_byte_reg; // held serial byte
  logic pend_data_reg; // held data/command flag

  wire bus_cmd = WR_STB & (ADDR == oled_init_pkg::REG_CMD);
  wire bus_data = WR_STB & (ADDR == oled_init_pkg::REG_DATA);
  wire bus_byte = bus_cmd | bus_data;
  // serial bytes queue for one slot so a port write never loses them
  wire ser_any = pend_reg | ser_valid;
  wire [7:0] ser_sel = pend_reg ? pend_byte_reg : ser_byte;
  wire ser_sel_data = pend_reg ? pend_data_reg : ser_is_data;
  // port write wins the cycle; serial byte waits
  wire take = (bus_byte | ser_any) & ~in_reset;
  wire [7:0] take_byte = bus_byte ? WDATA : ser_sel;
  wire take_data = bus_byte ? bus_data : ser_sel_data;
  wire take_cmd = take & ~take_data;

  // hold serial byte while the port owns the cycle
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pend_reg <= 1'b0;
      pend_byte_reg <= oled_init_pkg::BYTE_RST;
      pend_data_reg <= 1'b0;
    end else if (in_reset) begin
      pend_reg <= 1'b0; // partial traffic discarded
    end else if (bus_byte && ser_valid) begin
      pend_reg <= 1'b1;
      pend_byte_reg <= ser_byte;
      pend_data_reg <= ser_is_data;
    end else if (!bus_byte) begin
      pend_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // command decoding
  // ------------------------------------------------------------------
  // true when the byte equals the given 8-bit command code
  function automatic logic is_op(input logic [7:0] b, input logic [7:0] code);
    is_op = (b == code);
  endfunction : is_op

  oled_init_pkg::parse_state_t state_reg;
  oled_init_pkg::parse_state_t state_next;

  wire op_off = is_op(take_byte, oled_init_pkg::CMD_DISP_OFF);
  wire op_on = is_op(take_byte, oled_init_pkg::CMD_DISP_ON);
  wire op_contrast = is_op(take_byte, oled_init_pkg::CMD_CONTRAST);
  wire op_seg_n = is_op(take_byte, oled_init_pkg::CMD_SEG_NORM);
  wire op_seg_r = is_op(take_byte, oled_init_pkg::CMD_SEG_REMAP);
  wire op_ram = is_op(take_byte, oled_init_pkg::CMD_FOLLOW_RAM);
  wire op_all = is_op(take_byte, oled_init_pkg::CMD_ENTIRE_ON);
  wire op_norm = is_op(take_byte, oled_init_pkg::CMD_NORMAL);
  wire op_inv = is_op(take_byte, oled_init_pkg::CMD_INVERSE);
  wire op_mux = is_op(take_byte, oled_init_pkg::CMD_MUX);
  wire op_com_n = is_op(take_byte, oled_init_pkg::CMD_COM_NORM);
  wire op_com_r = is_op(take_byte, oled_init_pkg::CMD_COM_REV);
  wire op_start = (take_byte[7:6] == oled_init_pkg::CMD_START_TOP);
  wire op_col_lo = (take_byte[7:4] == oled_init_pkg::CMD_COL_LO_TOP);
  wire op_col_hi = (take_byte[7:4] == oled_init_pkg::CMD_COL_HI_TOP) & ~take_byte[3];
  wire at_opcode = (state_reg == oled_init_pkg::PARSE_OPCODE);
  wire do_op = take_cmd & at_opcode; // opcode byte accepted
  // mux ratios of 16 rows or fewer are not meaningful; keep the old value
  wire mux_ok = (take_byte[5:4] != 2'b00);

  // parser next state: two-byte commands take an argument
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      oled_init_pkg::PARSE_OPCODE: begin
        if (take_cmd && op_contrast) begin
          state_next = oled_init_pkg::PARSE_CONTRAST;
        end else if (take_cmd && op_mux) begin
          state_next = oled_init_pkg::PARSE_MUX;
        end
      end
      oled_init_pkg::PARSE_CONTRAST: begin
        if (take_cmd) state_next = oled_init_pkg::PARSE_OPCODE;
      end
      oled_init_pkg::PARSE_MUX: begin
        if (take_cmd) state_next = oled_init_pkg::PARSE_OPCODE;
      end
      default: begin
        state_next = oled_init_pkg::PARSE_OPCODE;
      end
    endcase
  end

  // parser state, back to opcode while the pin holds reset
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= oled_init_pkg::PARSE_OPCODE;
    end else if (in_reset) begin
      state_reg <= oled_init_pkg::PARSE_OPCODE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------------
  // display state registers
  // ------------------------------------------------------------------
  wire arg_contrast = take_cmd & (state_reg == oled_init_pkg::PARSE_CONTRAST);
  wire arg_mux = take_cmd & (state_reg == oled_init_pkg::PARSE_MUX);
  wire data_wr = take & take_data;
  wire col_wrap = (COL_ADDR == oled_init_pkg::COL_LAST);

  // on/off, mapping and mode flags
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DISPLAY_ON <= 1'b0;
      SEG_REMAP <= 1'b0;
      COM_REVERSE <= 1'b0;
      ENTIRE_ON <= 1'b0;
      INVERT <= 1'b0;
    end else if (in_reset) begin
      DISPLAY_ON <= 1'b0;
      SEG_REMAP <= 1'b0; // first segment driver at column 0
      COM_REVERSE <= 1'b0;
      ENTIRE_ON <= 1'b0; // follow memory
      INVERT <= 1'b0;
    end else if (do_op) begin
      if (op_off) DISPLAY_ON <= 1'b0;
      if (op_on) DISPLAY_ON <= 1'b1;
      if (op_seg_n) SEG_REMAP <= 1'b0;
      if (op_seg_r) SEG_REMAP <= 1'b1;
      if (op_com_n) COM_REVERSE <= 1'b0;
      if (op_com_r) COM_REVERSE <= 1'b1;
      if (op_ram) ENTIRE_ON <= 1'b0;
      if (op_all) ENTIRE_ON <= 1'b1;
      if (op_norm) INVERT <= 1'b0;
      if (op_inv) INVERT <= 1'b1;
    end
  end

  // contrast, geometry and start line
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CONTRAST <= oled_init_pkg::CONTRAST_RST;
      MUX_RATIO <= oled_init_pkg::MUX_RST;
      START_LINE <= oled_init_pkg::START_RST;
    end else if (in_reset) begin
      CONTRAST <= oled_init_pkg::CONTRAST_RST;
      MUX_RATIO <= oled_init_pkg::MUX_RST;
      START_LINE <= oled_init_pkg::START_RST;
    end else begin
      if (arg_contrast) CONTRAST <= take_byte;
      if (arg_mux && mux_ok) MUX_RATIO <= take_byte[5:0];
      if (do_op && op_start) START_LINE <= take_byte[5:0];
    end
  end

  // column counter: set by commands, advanced by data bytes
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      COL_ADDR <= oled_init_pkg::COL_RST;
    end else if (in_reset) begin
      COL_ADDR <= oled_init_pkg::COL_RST;
    end else if (data_wr) begin
      COL_ADDR <= col_wrap ? oled_init_pkg::COL_RST : COL_ADDR + 7'h01;
    end else if (do_op && op_col_lo) begin
      COL_ADDR <= {COL_ADDR[6:4], take_byte[3:0]};
    end else if (do_op && op_col_hi) begin
      COL_ADDR <= {take_byte[2:0], COL_ADDR[3:0]};
    end
  end

  // data byte strobe toward display memory
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DATA_STB <= 1'b0;
      DATA_BYTE <= oled_init_pkg::BYTE_RST;
    end else begin
      DATA_STB <= data_wr;
      if (data_wr) DATA_BYTE <= take_byte;
    end
  end

  // ready: pin released and parser waiting for an opcode
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CMD_READY <= 1'b0;
    end else begin
      CMD_READY <= ~in_reset & (state_next == oled_init_pkg::PARSE_OPCODE);
    end
  end

  // ------------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------------
  logic [7:0] status_word; // packed status flags
  logic [7:0] rd_mux; // selected read value

  // gather status flags
  always_comb begin
    status_word = 8'h00;
    status_word[oled_init_pkg::ST_DISPLAY_ON] = DISPLAY_ON;
    status_word[oled_init_pkg::ST_SEG_REMAP] = SEG_REMAP;
    status_word[oled_init_pkg::ST_COM_REVERSE] = COM_REVERSE;
    status_word[oled_init_pkg::ST_ENTIRE_ON] = ENTIRE_ON;
    status_word[oled_init_pkg::ST_INVERT] = INVERT;
    status_word[oled_init_pkg::ST_CMD_READY] = CMD_READY;
    status_word[oled_init_pkg::ST_IN_RESET] = in_reset;
  end

  // read selection; unmapped and write-only offsets read zero
  always_comb begin
    case (ADDR)
      oled_init_pkg::REG_STATUS: rd_mux = status_word;
      oled_init_pkg::REG_CONTRAST: rd_mux = CONTRAST;
      oled_init_pkg::REG_START: rd_mux = {2'b00, START_LINE};
      oled_init_pkg::REG_COLUMN: rd_mux = {1'b0, COL_ADDR};
      oled_init_pkg::REG_MUX: rd_mux = {2'b00, MUX_RATIO};
      default: rd_mux = 8'h00;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= RD_STB ? rd_mux : 8'h00;
    end
  end

endmodule : oled_reset_power_sequence
`default_nettype wire

/* hdl/serial_byte_receiver.sv */
// Purpose: assembles serial host bits into bytes with a command/data flag
// Assumes: serial clock far slower than CLK; pins are asynchronous
// Notes: clear input empties the shift register and drops a partial word
`timescale 1ns/1ns
`default_nettype none
module serial_byte_receiver #(
  parameter int BITS = oled_init_pkg::SER_BITS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic ser_clk,
  input wire logic ser_din,
  input wire logic ser_cs_n,
  input wire logic ser_dc,
  output logic byte_valid,
  output logic [BITS-1:0] byte_out,
  output logic byte_is_data
);

  if (BITS != 8) begin : g_bits_check
    $error("serial word must be 8 bits");
  end

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic [3:0] s1_reg; // first stage, read only by second stage
  logic [3:0] s2_reg; // {clk, din, cs_n, dc} second stage
  logic clk_d_reg; // delayed serial clock for edge detect
  logic [3:0] cnt_reg; // bits received so far
  logic [BITS-1:0] shift_reg; // word under assembly

  wire rise = s2_reg[3] & ~clk_d_reg; // serial clock rising edge
  wire selected = ~s2_reg[1]; // chip select active
  wire last_bit = (cnt_reg == 4'(BITS - 1));

  // two-flop synchroniser for all pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg <= 4'h2;
      s2_reg <= 4'h2;
      clk_d_reg <= 1'b0;
    end else begin
      s1_reg <= {ser_clk, ser_din, ser_cs_n, ser_dc};
      s2_reg <= s1_reg;
      clk_d_reg <= s2_reg[3];
    end
  end

  // shift register, cleared by reset or deselect
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= 4'h0;
      shift_reg <= '0;
      byte_valid <= 1'b0;
      byte_out <= '0;
      byte_is_data <= 1'b0;
    end else begin
      byte_valid <= 1'b0;
      if (clear || !selected) begin
        cnt_reg <= 4'h0;
        shift_reg <= '0;
      end else if (rise) begin
        shift_reg <= {shift_reg[BITS-2:0], s2_reg[2]};
        if (last_bit) begin
          cnt_reg <= 4'h0;
          byte_valid <= 1'b1;
          byte_out <= {shift_reg[BITS-2:0], s2_reg[2]};
          byte_is_data <= s2_reg[0];
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      end
    end
  end

endmodule : serial_byte_receiver
`default_nettype wire

/* pkg/oled_init_pkg.sv */
// Purpose: shared constants for the display controller reset and command core
// Assumes: 8-bit command bytes, 4-bit register port address
// Notes: reset values give display off, 128x64 geometry, normal mapping
package oled_init_pkg;

  // ------------------------------------------------------------------
  // register port offsets
  // ------------------------------------------------------------------
  localparam logic [3:0] REG_CMD = 4'h0; // write: command byte
  localparam logic [3:0] REG_DATA = 4'h1; // write: display data byte
  localparam logic [3:0] REG_STATUS = 4'h2; // read: status flags
  localparam logic [3:0] REG_CONTRAST = 4'h3; // read: contrast level
  localparam logic [3:0] REG_START = 4'h4; // read: display start line
  localparam logic [3:0] REG_COLUMN = 4'h5; // read: column address counter
  localparam logic [3:0] REG_MUX = 4'h6; // read: multiplex ratio

  // ------------------------------------------------------------------
  // status bit positions
  // ------------------------------------------------------------------
  localparam int ST_DISPLAY_ON = 0;
  localparam int ST_SEG_REMAP = 1;
  localparam int ST_COM_REVERSE = 2;
  localparam int ST_ENTIRE_ON = 3;
  localparam int ST_INVERT = 4;
  localparam int ST_CMD_READY = 5;
  localparam int ST_IN_RESET = 6;

  // ------------------------------------------------------------------
  // values after reset
  // ------------------------------------------------------------------
  localparam logic [7:0] CONTRAST_RST = 8'h7f; // mid-scale
  localparam logic [5:0] MUX_RST = 6'h3f; // 64 rows, full geometry
  localparam logic [5:0] START_RST = 6'h00; // first memory row
  localparam logic [6:0] COL_RST = 7'h00; // first column
  localparam logic [6:0] COL_LAST = 7'h7f; // 128 columns
  localparam logic [7:0] BYTE_RST = 8'h00;

  // ------------------------------------------------------------------
  // command codes
  // ------------------------------------------------------------------
  localparam logic [7:0] CMD_DISP_OFF = 8'hae;
  localparam logic [7:0] CMD_DISP_ON = 8'haf;
  localparam logic [7:0] CMD_CONTRAST = 8'h81;
  localparam logic [7:0] CMD_SEG_NORM = 8'ha0;
  localparam logic [7:0] CMD_SEG_REMAP = 8'ha1;
  localparam logic [7:0] CMD_FOLLOW_RAM = 8'ha4;
  localparam logic [7:0] CMD_ENTIRE_ON = 8'ha5;
  localparam logic [7:0] CMD_NORMAL = 8'ha6;
  localparam logic [7:0] CMD_INVERSE = 8'ha7;
  localparam logic [7:0] CMD_MUX = 8'ha8;
  localparam logic [7:0] CMD_COM_NORM = 8'hc0;
  localparam logic [7:0] CMD_COM_REV = 8'hc8;
  localparam logic [1:0] CMD_START_TOP = 2'b01; // 40h..7Fh
  localparam logic [3:0] CMD_COL_LO_TOP = 4'h0; // 00h..0Fh
  localparam logic [3:0] CMD_COL_HI_TOP = 4'h1; // 10h..17h

  // serial word length
  localparam int SER_BITS = 8;

  // command parser states
  typedef enum logic [1:0] {
    PARSE_OPCODE,
    PARSE_CONTRAST,
    PARSE_MUX
  } parse_state_t;

endpackage : oled_init_pkg

/* testbench/oled_host_model.sv */
// Purpose: host side model, serial byte sender and supply sequencing
// Assumes: serial clock idles low, stands still between frames
// Notes: SETTLE stands in for the 100ms supply waits
`timescale 1ns/1ns
`default_nettype none
module oled_host_model #(
  parameter int HALF = 4,
  parameter int SETTLE = 40
) (
  input wire logic clk,
  output logic ser_clk,
  output logic ser_din,
  output logic ser_cs_n,
  output logic ser_dc,
  output logic booster_supply
);
  // ---------------------------------------------
  // idle levels
  // ---------------------------------------------
  initial begin
    ser_clk = 1'b0;
    ser_din = 1'b0;
    ser_cs_n = 1'b1;
    ser_dc = 1'b0;
    booster_supply = 1'b0;
  end
  // n bits of b, msb first, select left low
  task automatic shift(input logic [7:0] b, input int n, input logic dc);
    @(posedge clk);
    ser_cs_n <= 1'b0;
    ser_dc <= dc;
    for (int i = 7; i > 7 - n; i--) begin
      ser_din <= b[i];
      repeat (HALF) @(posedge clk);
      ser_clk <= 1'b1;
      repeat (HALF) @(posedge clk);
      ser_clk <= 1'b0;
    end
  endtask : shift
  // whole byte, then select released and data line flipped
  task automatic send(input logic [7:0] b, input logic dc);
    shift(b, 8, dc);
    repeat (8) @(posedge clk);
    ser_cs_n <= 1'b1;
    ser_din <= ~b[0];
  endtask : send
  // off, init, clear, then supply and wait before display on
  task automatic power_up();
    send(8'hae, 1'b0);
    send(8'ha0, 1'b0);
    send(8'h00, 1'b1);
    booster_supply <= 1'b1;
    repeat (SETTLE) @(posedge clk);
    send(8'haf, 1'b0);
  endtask : power_up
  // off first, then supply off and discharge wait
  task automatic power_down();
    send(8'hae, 1'b0);
    booster_supply <= 1'b0;
    repeat (SETTLE) @(posedge clk);
  endtask : power_down
endmodule : oled_host_model
`default_nettype wire

/* testbench/oled_reset_checker_assertions.sv */
// Purpose: port checker for the display reset core
// Assumes: one CLK domain, RESET_N async active low, pin held 4 edges is synced
// Notes: bound to the top module after endmodule
`timescale 1ns/1ns
`default_nettype none
module oled_reset_checker (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic HW_RESET_N,
  input wire logic DISPLAY_ON,
  input wire logic [7:0] CONTRAST,
  input wire logic [5:0] MUX_RATIO,
  input wire logic [5:0] START_LINE,
  input wire logic [6:0] COL_ADDR,
  input wire logic SEG_REMAP,
  input wire logic COM_REVERSE,
  input wire logic ENTIRE_ON,
  input wire logic INVERT,
  input wire logic CMD_READY,
  input wire logic DATA_STB
);
  // ---------------------------------------------
  // defaults while the reset pin is held, column and ready at release
  // ---------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  AST_DISP_OFF: assert property (!HW_RESET_N [*4] |-> !DISPLAY_ON)
    else $error("display on while pin held");
  AST_FULL_GEOM: assert property (!HW_RESET_N [*4] |-> MUX_RATIO == 6'h3f)
    else $error("geometry not full while pin held");
  AST_SEG_MAP: assert property (!HW_RESET_N [*4] |-> !SEG_REMAP)
    else $error("segment remap while pin held");
  AST_NO_BYTE: assert property (!HW_RESET_N [*4] |-> !DATA_STB)
    else $error("data byte while pin held");
  AST_START_ROW: assert property ($fell(HW_RESET_N) ##1 !HW_RESET_N [*3] |-> START_LINE == 6'h00)
    else $error("start line not row zero");
  AST_COL_ZERO: assert property (!HW_RESET_N [*4] ##1 HW_RESET_N |-> COL_ADDR == 7'h00)
    else $error("column counter not zero at release");
  AST_COM_DIR: assert property (!HW_RESET_N [*4] |-> !COM_REVERSE)
    else $error("row scan reversed while pin held");
  AST_CONTRAST: assert property (!HW_RESET_N [*4] |-> CONTRAST == 8'h7f)
    else $error("contrast not mid scale");
  AST_NORMAL_MODE: assert property (!HW_RESET_N [*4] |-> !ENTIRE_ON && !INVERT)
    else $error("display mode not normal");
  AST_NOT_READY: assert property (!HW_RESET_N [*4] |=> !CMD_READY)
    else $error("ready while pin held");
  AST_READY_AFTER: assert property (!HW_RESET_N [*2] ##1 HW_RESET_N [*5] |-> CMD_READY)
    else $error("not ready after release");
endmodule : oled_reset_checker
bind oled_reset_power_sequence oled_reset_checker u_chk (.CLK(CLK), .RESET_N(RESET_N),
  .HW_RESET_N(HW_RESET_N), .DISPLAY_ON(DISPLAY_ON), .CONTRAST(CONTRAST), .MUX_RATIO(MUX_RATIO),
  .START_LINE(START_LINE), .COL_ADDR(COL_ADDR), .SEG_REMAP(SEG_REMAP), .COM_REVERSE(COM_REVERSE),
  .ENTIRE_ON(ENTIRE_ON), .INVERT(INVERT), .CMD_READY(CMD_READY), .DATA_STB(DATA_STB));
`default_nettype wire

/* testbench/oled_reset_power_sequence_tb.sv */
// Purpose: self-checking bench for the display reset core
// Assumes: 20 MHz clock, register port master in the bench, serial host model
// Notes: each scenario is a task that checks its own results
`timescale 1ns/1ns
`default_nettype none
module oled_reset_power_sequence_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hw_reset_n = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic ser_clk, ser_din, ser_cs_n, ser_dc, booster_supply;
  logic [7:0] rdata, contrast, data_byte, last_byte;
  logic [5:0] mux_ratio, start_line;
  logic [6:0] col_addr;
  logic display_on, seg_remap, com_reverse, entire_on, invert, cmd_ready, data_stb;
  int fail_count = 0;
  int n_compared = 0;
  int stb_count = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  oled_reset_power_sequence dut (.CLK(clk), .RESET_N(reset_n), .HW_RESET_N(hw_reset_n),
    .SER_CLK(ser_clk), .SER_DIN(ser_din), .SER_CS_N(ser_cs_n), .SER_DC(ser_dc), .ADDR(addr),
    .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .DISPLAY_ON(display_on),
    .CONTRAST(contrast), .MUX_RATIO(mux_ratio), .START_LINE(start_line), .COL_ADDR(col_addr),
    .SEG_REMAP(seg_remap), .COM_REVERSE(com_reverse), .ENTIRE_ON(entire_on), .INVERT(invert),
    .CMD_READY(cmd_ready), .DATA_STB(data_stb), .DATA_BYTE(data_byte));
  oled_host_model host (.clk(clk), .ser_clk(ser_clk), .ser_din(ser_din), .ser_cs_n(ser_cs_n),
    .ser_dc(ser_dc), .booster_supply(booster_supply));
  // ---------------------------------------------
  // data strobe counter and hang limit
  // ---------------------------------------------
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (data_stb === 1'b1) begin
      stb_count <= stb_count + 1;
      last_byte <= data_byte;
    end
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      complete_run();
    end
  end
  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : rd
  task automatic wait_ready();
    for (int i = 0; i < 12 && cmd_ready !== 1'b1; i++) @(negedge clk);
  endtask : wait_ready
  // every default at the ports and the status view
  task automatic check_defaults(input logic [7:0] st);
    logic [7:0] v;
    chk({7'h00, display_on}, 8'h00, "display");
    chk({2'b00, mux_ratio}, 8'h3f, "mux");
    chk({7'h00, seg_remap}, 8'h00, "seg map");
    chk({2'b00, start_line}, 8'h00, "start");
    chk({1'b0, col_addr}, 8'h00, "column");
    chk({7'h00, com_reverse}, 8'h00, "row scan");
    chk(contrast, 8'h7f, "contrast");
    chk({6'h00, entire_on, invert}, 8'h00, "mode");
    rd(oled_init_pkg::REG_STATUS, v);
    chk(v, st, "status");
  endtask : check_defaults
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_commands();
    logic [7:0] v;
    wait_ready();
    check_defaults(8'h20);
    wr(4'h0, 8'haf);
    wr(4'h0, 8'ha1);
    wr(4'h0, 8'hc8);
    wr(4'h0, 8'ha5);
    wr(4'h0, 8'ha7);
    wr(4'h0, 8'h81);
    wr(4'h0, 8'h10);
    wr(4'h0, 8'h4a);
    wr(4'h0, 8'h05);
    wr(4'h0, 8'h12);
    wr(4'h0, 8'ha8);
    wr(4'h0, 8'h1f);
    repeat (2) @(negedge clk);
    chk({3'h0, display_on, seg_remap, com_reverse, entire_on, invert}, 8'h1f, "flags");
    chk(contrast, 8'h10, "contrast set");
    chk({2'b00, start_line}, 8'h0a, "start set");
    chk({1'b0, col_addr}, 8'h25, "column set");
    chk({2'b00, mux_ratio}, 8'h1f, "mux set");
    rd(4'hf, v);
    chk(v, 8'h00, "unmapped");
    $display("test commands done");
  endtask : t_commands
  // pin pulled low over a changed state, a write tried meanwhile
  task automatic t_hw_reset();
    @(posedge clk);
    hw_reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    wr(4'h0, 8'haf);
    repeat (20) @(negedge clk);
    check_defaults(8'h40);
    @(posedge clk);
    hw_reset_n <= 1'b1;
    wait_ready();
    check_defaults(8'h20);
    $display("test hw reset done");
  endtask : t_hw_reset
  task automatic t_serial();
    int n;
    host.send(8'h81, 1'b0);
    host.send(8'h33, 1'b0);
    chk(contrast, 8'h33, "serial contrast");
    n = stb_count;
    host.send(8'h5a, 1'b1);
    chk(8'(stb_count - n), 8'h01, "strobes");
    chk(last_byte, 8'h5a, "data byte");
    chk({1'b0, col_addr}, 8'h01, "column step");
    $display("test serial done");
  endtask : t_serial
  // noise leaves half a word; the display is reset to recover
  task automatic t_partial();
    host.shift(8'hf0, 4, 1'b0);
    @(posedge clk);
    hw_reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    hw_reset_n <= 1'b1;
    wait_ready();
    host.send(8'ha1, 1'b0);
    chk({7'h00, seg_remap}, 8'h01, "clean word");
    $display("test partial done");
  endtask : t_partial
  task automatic t_power();
    int n;
    n = stb_count;
    host.power_up();
    chk({7'h00, display_on}, 8'h01, "powered on");
    chk(8'(stb_count - n), 8'h01, "clear byte");
    host.power_down();
    chk({6'h00, display_on, booster_supply}, 8'h00, "powered off");
    $display("test power done");
  endtask : t_power
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    t_commands();
    t_hw_reset();
    t_serial();
    t_partial();
    t_power();
    complete_run();
  end
endmodule : oled_reset_power_sequence_tb
`default_nettype wire
